// ==== pkg/rbt_defines.svh ====
`ifndef RBT_DEFINES_SVH
`define RBT_DEFINES_SVH

`define RBT_BUS_W        8
`define RBT_ADDR_W       4
`define RBT_DATA_W       32
`define RBT_OFF_CTRL     4'h0
`define RBT_OFF_STORE    4'h4
`define RBT_OFF_LIVE     4'h8
`define RBT_CTRL_RESET   4'h1
`define RBT_CTRL_LANE    0
`define RBT_RESP_OKAY    2'h0
`define RBT_RESP_SLVERR  2'h2
`define RBT_PIN_TO_OUT   3

`endif

// ==== pkg/rbt_pkg.sv ====
`include "rbt_defines.svh"

package rbt_pkg;

  // control register layout, bit 3 downward
  typedef struct packed {
    logic bSideSourceSelect;
    logic aSideSourceSelect;
    logic direction;
    logic outDisable;
  } rbt_ctrl_type;

  // one bus pin group as seen by the output stage
  typedef struct packed {
    logic                  oe;
    logic [`RBT_BUS_W-1:0] data;
  } rbt_drive_type;

endpackage

// ==== core/rbt_pin_sync.sv ====
module rbt_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    meta_q  <= pinIn;
    syncOut <= meta_q;
  end

endmodule

// ==== core/rbt_store_reg.sv ====
module rbt_store_reg #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] dataIn,
  output logic      [W-1:0] storeOut
);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      storeOut <= '0;
    end else if (load) begin
      storeOut <= dataIn;
    end
  end

endmodule

// ==== core/rbt_transceiver.sv ====
`include "rbt_defines.svh"

module rbt_transceiver
  import rbt_pkg::*;
#(
  parameter int BUS_W = `RBT_BUS_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   aToBLoadClock,
  input  wire logic                   bToALoadClock,
  input  wire logic [BUS_W-1:0]       busAIn,
  output logic      [BUS_W-1:0]       busAOut,
  output logic                        busAOe,
  input  wire logic [BUS_W-1:0]       busBIn,
  output logic      [BUS_W-1:0]       busBOut,
  output logic                        busBOe,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`RBT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [`RBT_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic      [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`RBT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic      [`RBT_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]             s_axi_rresp
);

  rbt_ctrl_type          ctrlQ;
  logic [1:0]            loadClkSync;
  logic [1:0]            loadClkDly_q;
  logic                  loadAbRise;
  logic                  loadBaRise;
  logic [2*BUS_W-1:0]    busSync;
  logic [BUS_W-1:0]      busASync;
  logic [BUS_W-1:0]      busBSync;
  logic [BUS_W-1:0]      storeAb;
  logic [BUS_W-1:0]      storeBa;
  logic [`RBT_ADDR_W-1:0] awAddr_q;
  logic [`RBT_DATA_W-1:0] wData_q;
  logic [3:0]            wStrb_q;
  logic                  doWrite;
  logic [`RBT_DATA_W-1:0] readWord;
  logic                  readOk;

  // pins from outside the clock domain
  rbt_pin_sync #(
    .W (2)
  ) u_clk_sync (
    .clk_sys (clk_sys),
    .pinIn   ({bToALoadClock, aToBLoadClock}),
    .syncOut (loadClkSync)
  );

  rbt_pin_sync #(
    .W (2 * BUS_W)
  ) u_bus_sync (
    .clk_sys (clk_sys),
    .pinIn   ({busBIn, busAIn}),
    .syncOut (busSync)
  );

  assign busASync = busSync[BUS_W-1:0];
  assign busBSync = busSync[2*BUS_W-1:BUS_W];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      loadClkDly_q <= 2'h3;
    end else begin
      loadClkDly_q <= loadClkSync;
    end
  end

  // rising edge of each load clock, independent of the other
  assign loadAbRise = loadClkSync[0] && !loadClkDly_q[0];
  assign loadBaRise = loadClkSync[1] && !loadClkDly_q[1];

  // capture is never qualified by the output controls
  rbt_store_reg #(
    .W (BUS_W)
  ) u_store_ab (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .load     (loadAbRise),
    .dataIn   (busASync),
    .storeOut (storeAb)
  );

  rbt_store_reg #(
    .W (BUS_W)
  ) u_store_ba (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .load     (loadBaRise),
    .dataIn   (busBSync),
    .storeOut (storeBa)
  );

  // output enables: never both, none while disabled
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busAOe <= 1'b0;
      busBOe <= 1'b0;
    end else begin
      busAOe <= !ctrlQ.outDisable && !ctrlQ.direction;
      busBOe <= !ctrlQ.outDisable && ctrlQ.direction;
    end
  end

  // output data: live from the far bus or stored word
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busAOut <= '0;
      busBOut <= '0;
    end else begin
      busAOut <= ctrlQ.aSideSourceSelect ? storeBa : busBSync;
      busBOut <= ctrlQ.bSideSourceSelect ? storeAb : busASync;
    end
  end

  // write channel: address and data taken in either order
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      awAddr_q      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awAddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      wData_q      <= '0;
      wStrb_q      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wData_q      <= s_axi_wdata;
      wStrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RBT_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_q == `RBT_OFF_CTRL) ? `RBT_RESP_OKAY : `RBT_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register, byte lane 0 only
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrlQ <= rbt_ctrl_type'(`RBT_CTRL_RESET);
    end else if (doWrite && awAddr_q == `RBT_OFF_CTRL && wStrb_q[`RBT_CTRL_LANE]) begin
      ctrlQ <= rbt_ctrl_type'(wData_q[$bits(rbt_ctrl_type)-1:0]);
    end
  end

  // read decode
  always_comb begin
    readWord = '0;
    readOk   = 1'b1;
    unique case (s_axi_araddr)
      `RBT_OFF_CTRL: begin
        readWord[$bits(rbt_ctrl_type)-1:0] = ctrlQ;
      end
      `RBT_OFF_STORE: begin
        readWord[2*BUS_W-1:0] = {storeBa, storeAb};
      end
      `RBT_OFF_LIVE: begin
        readWord[2*BUS_W-1:0] = {busBSync, busASync};
      end
      default: begin
        readOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `RBT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readWord;
      s_axi_rresp   <= readOk ? `RBT_RESP_OKAY : `RBT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (!resetn);

  capture_ab_a: assert property (loadAbRise |=> storeAb == $past(busASync))
    else $error("a-to-b register missed its load edge");

  hold_ab_a: assert property (!loadAbRise |=> $stable(storeAb))
    else $error("a-to-b register changed without a load edge");

  capture_enabled_a: assert property (
    loadBaRise && !ctrlQ.outDisable |=> storeBa == $past(busBSync))
    else $error("b-to-a capture gated by output controls");

  isolation_drive_a: assert property (
    ctrlQ.outDisable [*2] |-> !busAOe && !busBOe)
    else $error("a bus driven while outputs disabled");

  isolation_load_a: assert property (
    ctrlQ.outDisable && loadBaRise |=> storeBa == $past(busBSync))
    else $error("b data not stored during isolation");

  both_load_a: assert property (
    ctrlQ.outDisable && loadAbRise && loadBaRise
    |=> storeAb == $past(busASync) && storeBa == $past(busBSync))
    else $error("simultaneous store lost a word");

  direction_sel_a: assert property (
    !$past(ctrlQ.outDisable) |-> busAOe == !$past(ctrlQ.direction)
                                 && busBOe == $past(ctrlQ.direction))
    else $error("direction did not pick the driven bus");

  live_to_a_a: assert property (
    busAOe && !$past(ctrlQ.aSideSourceSelect) |-> busAOut == $past(busBSync))
    else $error("bus a not fed from live bus b");

  stored_to_a_a: assert property (
    busAOe && $past(ctrlQ.aSideSourceSelect) |-> busAOut == $past(storeBa))
    else $error("bus a not fed from stored b data");

  live_to_b_a: assert property (
    busBOe && !$past(ctrlQ.bSideSourceSelect) |-> busBOut == $past(busASync))
    else $error("bus b not fed from live bus a");

  stored_to_b_a: assert property (
    busBOe && $past(ctrlQ.bSideSourceSelect) |-> busBOut == $past(storeAb))
    else $error("bus b not fed from stored a data");

  undriven_load_a: assert property (
    busAOe && loadBaRise ##1 busAOe |-> storeBa == $past(busBSync))
    else $error("undriven bus b not stored while driving a");

  one_driver_a: assert property (!(busAOe && busBOe))
    else $error("both buses driven at once");

  clock_indep_a: assert property (
    loadAbRise && !loadBaRise |=> $stable(storeBa))
    else $error("a-to-b load disturbed the b-to-a register");

  write_answer_a: assert property (
    doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised after both halves");

  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not raised one cycle after address");

  // second register and the cases the first set leaves open
  capture_ba_a: assert property (loadBaRise |=> storeBa == $past(busBSync))
    else $error("b-to-a register missed its load edge");

  hold_ba_a: assert property (!loadBaRise |=> $stable(storeBa))
    else $error("b-to-a register changed without a load edge");

  capture_ab_open_a: assert property (
    loadAbRise && !ctrlQ.outDisable |=> storeAb == $past(busASync))
    else $error("a-to-b capture gated by output controls");

  isolation_ab_a: assert property (
    ctrlQ.outDisable && loadAbRise |=> storeAb == $past(busASync))
    else $error("a data not stored during isolation");

  isolation_oe_a: assert property (
    $past(ctrlQ.outDisable) |-> !busAOe && !busBOe)
    else $error("output enable raised while control disabled");

  undriven_a_load_a: assert property (
    busBOe && loadAbRise ##1 busBOe |-> storeAb == $past(busASync))
    else $error("undriven bus a not stored while driving b");

  clock_indep_b_a: assert property (
    loadBaRise && !loadAbRise |=> $stable(storeAb))
    else $error("b-to-a load disturbed the a-to-b register");

  // register bus bookkeeping
  ctrl_update_a: assert property (
    doWrite && awAddr_q == `RBT_OFF_CTRL && wStrb_q[`RBT_CTRL_LANE]
    |=> ctrlQ == rbt_ctrl_type'($past(wData_q[$bits(rbt_ctrl_type)-1:0])))
    else $error("control write did not land");

  ctrl_keep_a: assert property (!doWrite |=> $stable(ctrlQ))
    else $error("control changed without a write");

  write_error_a: assert property (
    doWrite && awAddr_q != `RBT_OFF_CTRL |=> s_axi_bresp == `RBT_RESP_SLVERR)
    else $error("write outside control not refused");

  read_error_a: assert property (
    s_axi_arvalid && s_axi_arready && !readOk
    |=> s_axi_rresp == `RBT_RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");

  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted while data pending");

  aw_busy_a: assert property (
    !s_axi_awready && !(s_axi_bvalid && s_axi_bready) |=> !s_axi_awready)
    else $error("write address ready rose before the response");

  both_store_c: cover property (ctrlQ.outDisable && loadAbRise && loadBaRise);

  stored_to_a_c: cover property (busAOe && ctrlQ.aSideSourceSelect ##1 busAOe);

  live_to_b_c: cover property (busBOe && !ctrlQ.bSideSourceSelect && loadAbRise);

  ctrl_write_c: cover property (doWrite && awAddr_q == `RBT_OFF_CTRL);

  isolation_ba_c: cover property (ctrlQ.outDisable && loadBaRise && !loadAbRise);

endmodule

// ==== tb/rbt_bus_partner.sv ====
module rbt_bus_partner (
  input  wire logic       busAOe,
  input  wire logic [7:0] busAOut,
  input  wire logic       busBOe,
  input  wire logic [7:0] busBOut,
  input  wire logic [7:0] extA,
  input  wire logic [7:0] extB,
  output logic      [7:0] busAIn,
  output logic      [7:0] busBIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // far-side logic drives a bus only while the device leaves it undriven
  assign busAIn = busAOe ? busAOut : extA;
  assign busBIn = busBOe ? busBOut : extB;
endmodule

// ==== tb/rbt_transceiver_test.sv ====
module rbt_transceiver_test
  import rbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, resetn, aClk, bClk, busAOe, busBOe;
  logic [7:0]  extA, extB, busAIn, busBIn, busAOut, busBOut, storeAb, storeBa, ex;
  logic        awValid, awReady, wValid, wReady, bValid, bReady;
  logic        arValid, arReady, rValid, rReady;
  logic [3:0]  awAddr, arAddr, wStrb;
  logic [31:0] wData, rData;
  logic [1:0]  bResp, rResp;
  logic [1:0]  expB[$];
  logic [33:0] expR[$];
  logic [31:0] tbl[4] = '{32'h0, 32'h4, 32'h2, 32'hA};
  int          badCount, compares;

  rbt_transceiver dut_u (.clk_sys(clk_sys), .resetn(resetn), .aToBLoadClock(aClk),
    .bToALoadClock(bClk), .busAIn(busAIn), .busAOut(busAOut), .busAOe(busAOe),
    .busBIn(busBIn), .busBOut(busBOut), .busBOe(busBOe), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp));

  rbt_bus_partner far_u (.busAOe(busAOe), .busAOut(busAOut), .busBOe(busBOe),
    .busBOut(busBOut), .extA(extA), .extB(extB), .busAIn(busAIn), .busBIn(busBIn));

  task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 60) begin
      badCount++;
      results();
    end
  endtask

  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    expB.push_back(r);
    awValid <= 1'b1;
    wValid <= 1'b1;
    awAddr <= a;
    wData <= d;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid && n < 60);
    bReady <= 1'b0;
    @(posedge clk_sys);
    tmo(n);
  endtask

  task automatic axiRd(input logic [3:0] a, input logic [33:0] e);
    int n;
    n = 0;
    expR.push_back(e);
    arValid <= 1'b1;
    arAddr <= a;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arReady) arValid <= 1'b0;
    end while (!rValid && n < 60);
    rReady <= 1'b0;
    @(posedge clk_sys);
    tmo(n);
  endtask

  task automatic setBus(input logic [7:0] a, input logic [7:0] b);
    extA <= a;
    extB <= b;
    repeat (7) @(posedge clk_sys);
  endtask

  task automatic pulse(input logic a, input logic b);
    aClk <= a;
    bClk <= b;
    repeat (4) @(posedge clk_sys);
    aClk <= 1'b0;
    bClk <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    if (rValid && rReady) cmp("rdata", expR.pop_front(), {rResp, rData});
    if (bValid && bReady) cmp("bresp", {32'h0, expB.pop_front()}, {32'h0, bResp});
  end

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    {resetn, aClk, bClk, awValid, wValid, arValid, bReady, rReady} = '0;
    {extA, extB, awAddr, arAddr, wData} = '0;
    wStrb = 4'hF;
    void'($urandom(30805));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    axiRd(4'h0, 34'h1);
    axiRd(4'h4, 34'h0);
    cmp("oe", 34'h0, {32'h0, busAOe, busBOe});
    $display("test reset done");
    setBus(8'($urandom), 8'($urandom));
    pulse(1'b1, 1'b1);
    storeAb = extA;
    storeBa = extB;
    axiRd(4'h4, {18'h0, storeBa, storeAb});
    setBus(8'($urandom), 8'($urandom));
    pulse(1'b1, 1'b0);
    storeAb = extA;
    axiRd(4'h4, {18'h0, storeBa, storeAb});
    axiRd(4'h8, {18'h0, extB, extA});
    pulse(1'b0, 1'b1);
    storeBa = extB;
    axiRd(4'h4, {18'h0, storeBa, storeAb});
    $display("test isolation done");
    for (int i = 0; i < 4; i++) begin
      setBus(8'($urandom), 8'($urandom));
      axiWr(4'h0, tbl[i], 2'h0);
      repeat (5) @(posedge clk_sys);
      ex = (i == 0) ? extB : (i == 1) ? storeBa : (i == 2) ? extA : storeAb;
      cmp("oe", {32'h0, (i < 2) ? 2'b10 : 2'b01}, {32'h0, busAOe, busBOe});
      cmp("drive", {26'h0, ex}, {26'h0, (i < 2) ? busAOut : busBOut});
    end
    $display("test sources done");
    axiWr(4'h0, 32'h0, 2'h0);
    setBus(8'($urandom), 8'($urandom));
    pulse(1'b1, 1'b1);
    storeBa = extB;
    storeAb = extB;
    axiRd(4'h4, {18'h0, storeBa, storeAb});
    $display("test transceiver store done");
    axiRd(4'hC, {2'h2, 32'h0});
    axiWr(4'h4, 32'hFF, 2'h2);
    axiRd(4'h4, {18'h0, storeBa, storeAb});
    axiWr(4'h0, 32'hF, 2'h0);
    repeat (3) @(posedge clk_sys);
    cmp("oe", 34'h0, {32'h0, busAOe, busBOe});
    wStrb <= 4'hE;
    axiWr(4'h0, 32'h0, 2'h0);
    wStrb <= 4'hF;
    axiRd(4'h0, 34'hF);
    $display("test refusals done");
    results();
  end
endmodule
